// file: core/ddrbp_core.sv
`timescale 1ns/1ps
module ddrbp_core #(
   parameter int NUM_BANKS = 8,
   parameter int SCHED_DEPTH = 16
) (
   // clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic CORE_CE,
   // command pins
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic BANK_SELECT_BIT0,
   input wire logic BANK_SELECT_BIT1,
   input wire logic BANK_SELECT_BIT2,
   input wire logic [12:0] ADDR,
   // write data, both beats of one clock, with one mask bit per byte
   input wire logic [31:0] DQ_PAIR,
   input wire logic [3:0] WRITE_BYTE_MASK,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // array write port
   output logic ARRAY_WE,
   output logic [2:0] ARRAY_WR_BANK,
   output logic [9:0] ARRAY_WR_COL,
   output logic [31:0] ARRAY_WDATA,
   output logic [3:0] ARRAY_BYTE_EN,
   // array read port
   output logic ARRAY_RE,
   output logic [2:0] ARRAY_RD_BANK,
   output logic [9:0] ARRAY_RD_COL,
   // bank state
   output logic [7:0] BANK_OPEN,
   output logic [7:0] BANK_PRECHARGING
);
   // refuse configurations the decode and schedule cannot serve
   if (NUM_BANKS != 8 || SCHED_DEPTH < 15) begin : bad_cfg
      $error("ddrbp_core needs eight banks and a schedule depth of at least 15");
   end

   // two-flop synchroniser on every pin, data and commands delayed alike
   logic [55:0] pin_s1;
   logic [55:0] pin_s2;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         pin_s1 <= ddrbp_pkg::PIN_IDLE;
         pin_s2 <= ddrbp_pkg::PIN_IDLE;
      end else if (CORE_CE) begin
         pin_s1 <= {CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT_BIT2, BANK_SELECT_BIT1, BANK_SELECT_BIT0,
                    ADDR, DQ_PAIR, WRITE_BYTE_MASK};
         pin_s2 <= pin_s1;
      end
   end
   wire [3:0] cmd = pin_s2[55:52];
   wire [2:0] bank = pin_s2[51:49];
   wire [12:0] addr = pin_s2[48:36];
   wire [31:0] dq = pin_s2[35:4];
   wire [3:0] mask = pin_s2[3:0];

   // software registers
   logic [3:0] mode_reg;
   logic [10:0] lat_reg;
   logic [19:0] tim_reg;
   wire bl8 = (mode_reg[ddrbp_pkg::MODE_BL_LSB +: 3] == ddrbp_pkg::BL_CODE_8);
   wire interleave = mode_reg[ddrbp_pkg::MODE_ORDER_BIT];
   wire [2:0] half = bl8 ? 3'h4 : 3'h2;
   wire [2:0] al = lat_reg[ddrbp_pkg::LAT_AL_LSB +: 3];
   wire [2:0] cl_raw = lat_reg[ddrbp_pkg::LAT_CL_LSB +: 3];
   wire [2:0] cl = (cl_raw < ddrbp_pkg::CL_MIN) ? ddrbp_pkg::CL_MIN : cl_raw;
   wire [2:0] wrec = lat_reg[ddrbp_pkg::LAT_WR_LSB +: 3];
   wire [4:0] min_active_time = tim_reg[ddrbp_pkg::TIM_MIN_ACTIVE_TIME_LSB +: 5];
   wire [3:0] rtp_raw = tim_reg[ddrbp_pkg::TIM_RTP_LSB +: 4];
   wire [3:0] trp_raw = tim_reg[ddrbp_pkg::TIM_TRP_LSB +: 4];
   wire [3:0] row_precharge_time = (trp_raw == 4'h0) ? 4'h1 : trp_raw;
   wire [4:0] min_active_time_eff = (min_active_time == 5'h00) ? 5'h01 : min_active_time;

   // write latency from the additive and cas latencies, internal precharge delays also from the programmed burst length
   wire [3:0] wl = {1'b0, al} + {1'b0, cl} - 4'h1;
   wire [3:0] read_to_precharge_cycles = (rtp_raw < ddrbp_pkg::RTP_FLOOR) ? ddrbp_pkg::RTP_FLOOR : rtp_raw;
   wire [2:0] prefetch_ofs = bl8 ? ddrbp_pkg::PREFETCH_STEP : 3'h0;
   wire [5:0] rd_ap_delay = {3'h0, al} + {3'h0, half};
   wire [5:0] wr_ap_delay = {2'h0, wl} + {3'h0, half} + {3'h0, wrec};
   wire [5:0] rtp_delay = {3'h0, al} + {3'h0, prefetch_ofs} + {2'h0, read_to_precharge_cycles};

   // command decode
   wire is_act = (cmd == ddrbp_pkg::CMD_ACTIVATE);
   wire is_rd = (cmd == ddrbp_pkg::CMD_READ);
   wire is_wr = (cmd == ddrbp_pkg::CMD_WRITE);
   wire is_pre = (cmd == ddrbp_pkg::CMD_PRECHARGE);
   wire ap_bit = addr[ddrbp_pkg::PRECHARGE_ALL_BIT_POS];
   wire [14:0] cur_entry = {is_rd || is_wr, is_wr, bank, addr[9:0]};

   // per-bank state
   logic [7:0] bank_open;
   logic [7:0] bank_pre;
   logic [7:0] bank_ap;
   for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
      wire hit = (bank == 3'(i));
      ddrbp_bank u_bank (
         .clk(CORE_CLK),
         .reset(RESET),
         .ce(CORE_CE),
         .activate(is_act && hit),
         .precharge(is_pre && (ap_bit || hit)),
         .access((is_rd || is_wr) && hit),
         .access_write(is_wr),
         .auto_pre(ap_bit),
         .ap_delay(is_wr ? wr_ap_delay : rd_ap_delay),
         .rtp_delay(rtp_delay),
         .min_active_time(min_active_time_eff),
         .row_precharge_time(row_precharge_time),
         .is_open(bank_open[i]),
         .is_precharging(bank_pre[i]),
         .ap_pending(bank_ap[i])
      );
   end
   assign BANK_OPEN = bank_open;
   assign BANK_PRECHARGING = bank_pre;

   // column schedule: entry k holds the access seen k+1 cycles ago
   logic [14:0] sched [0:SCHED_DEPTH-1];
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         for (int k = 0; k < SCHED_DEPTH; k++) begin
            sched[k] <= 15'h0;
         end
      end else if (CORE_CE) begin
         sched[0] <= cur_entry;
         for (int k = 1; k < SCHED_DEPTH; k++) begin
            sched[k] <= sched[k-1];
         end
      end
   end
   wire [14:0] rd_entry = (al == 3'h0) ? cur_entry : sched[al - 3'h1];
   wire [14:0] wr_entry = sched[wl - 4'h1];
   wire rd_tap = rd_entry[ddrbp_pkg::ENT_VALID] && !rd_entry[ddrbp_pkg::ENT_WRITE];
   wire wr_tap = wr_entry[ddrbp_pkg::ENT_VALID] && wr_entry[ddrbp_pkg::ENT_WRITE];

   // column of the first beat of beat pair k, nibble based order
   function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [1:0] k, input logic ilv);
      logic [1:0] lo;
      lo = ilv ? (s[1:0] ^ {k[0], 1'b0}) : (s[1:0] + {k[0], 1'b0});
      return {s[2] ^ k[1], lo};
   endfunction

   // write burst engine; a new write tap restarts it on any bank
   logic [2:0] wr_left;
   logic [1:0] wr_k;
   logic [9:0] wr_base;
   logic [2:0] wr_bank;
   wire wr_go = wr_tap || (wr_left != 3'h0);
   wire [1:0] wr_k_now = wr_tap ? 2'h0 : wr_k;
   wire [9:0] wr_base_now = wr_tap ? wr_entry[9:0] : wr_base;
   wire [2:0] wr_bank_now = wr_tap ? wr_entry[ddrbp_pkg::ENT_BANK_LSB +: 3] : wr_bank;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         wr_left <= 3'h0;
         wr_k <= 2'h0;
         wr_base <= 10'h000;
         wr_bank <= 3'h0;
      end else if (CORE_CE) begin
         wr_left <= wr_tap ? half - 3'h1 : (wr_go ? wr_left - 3'h1 : wr_left);
         wr_k <= wr_k_now + 2'h1;
         wr_base <= wr_base_now;
         wr_bank <= wr_bank_now;
      end
   end

   // read burst engine, same shape, mask never consulted
   logic [2:0] rd_left;
   logic [1:0] rd_k;
   logic [9:0] rd_base;
   logic [2:0] rd_bank;
   wire rd_go = rd_tap || (rd_left != 3'h0);
   wire [1:0] rd_k_now = rd_tap ? 2'h0 : rd_k;
   wire [9:0] rd_base_now = rd_tap ? rd_entry[9:0] : rd_base;
   wire [2:0] rd_bank_now = rd_tap ? rd_entry[ddrbp_pkg::ENT_BANK_LSB +: 3] : rd_bank;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rd_left <= 3'h0;
         rd_k <= 2'h0;
         rd_base <= 10'h000;
         rd_bank <= 3'h0;
      end else if (CORE_CE) begin
         rd_left <= rd_tap ? half - 3'h1 : (rd_go ? rd_left - 3'h1 : rd_left);
         rd_k <= rd_k_now + 2'h1;
         rd_base <= rd_base_now;
         rd_bank <= rd_bank_now;
      end
   end

   // registered array ports; the mask gates byte lanes on writes only
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ARRAY_WE <= 1'b0;
         ARRAY_WR_BANK <= 3'h0;
         ARRAY_WR_COL <= 10'h000;
         ARRAY_WDATA <= 32'h00000000;
         ARRAY_BYTE_EN <= 4'h0;
         ARRAY_RE <= 1'b0;
         ARRAY_RD_BANK <= 3'h0;
         ARRAY_RD_COL <= 10'h000;
      end else if (CORE_CE) begin
         ARRAY_WE <= wr_go;
         ARRAY_WR_BANK <= wr_bank_now;
         ARRAY_WR_COL <= {wr_base_now[9:3], beat_col(wr_base_now[2:0], wr_k_now, interleave)};
         ARRAY_WDATA <= dq;
         ARRAY_BYTE_EN <= wr_go ? ~mask : 4'h0;
         ARRAY_RE <= rd_go;
         ARRAY_RD_BANK <= rd_bank_now;
         ARRAY_RD_COL <= {rd_base_now[9:3], beat_col(rd_base_now[2:0], rd_k_now, interleave)};
      end
   end

   // ahb-lite slave: zero wait states, always okay
   wire ahb_go = HSEL && HREADY && HTRANS[1];
   wire [11:0] ahb_off = HADDR[11:0];
   wire [31:0] status_word = {14'h0, ARRAY_RE, ARRAY_WE, bank_pre, bank_open};
   wire [31:0] rd_mux = (ahb_off == ddrbp_pkg::OFF_MODE) ? {28'h0000000, mode_reg} :
                        (ahb_off == ddrbp_pkg::OFF_LATENCY) ? {21'h0, lat_reg} :
                        (ahb_off == ddrbp_pkg::OFF_TIMING) ? {12'h000, tim_reg} :
                        (ahb_off == ddrbp_pkg::OFF_STATUS) ? status_word : 32'h00000000;
   logic wr_pend;
   logic [11:0] wr_off;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         wr_pend <= 1'b0;
         wr_off <= 12'h000;
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else if (CORE_CE) begin
         wr_pend <= ahb_go && HWRITE;
         wr_off <= ahb_off;
         if (ahb_go && !HWRITE) begin
            HRDATA <= rd_mux;
         end
      end
   end

   // register writes in the data phase
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         mode_reg <= ddrbp_pkg::MODE_RESET;
         lat_reg <= ddrbp_pkg::LATENCY_RESET;
         tim_reg <= ddrbp_pkg::TIMING_RESET;
      end else if (CORE_CE && wr_pend) begin
         if (wr_off == ddrbp_pkg::OFF_MODE) begin
            mode_reg <= HWDATA[3:0];
         end
         if (wr_off == ddrbp_pkg::OFF_LATENCY) begin
            lat_reg <= HWDATA[10:0];
         end
         if (wr_off == ddrbp_pkg::OFF_TIMING) begin
            tim_reg <= HWDATA[19:0];
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET || !CORE_CE);

   AST_PRE_ALL: assert property (is_pre && ap_bit && !is_act |=> BANK_OPEN == 8'h00)
      else $error("precharge all left a bank open");
   AST_PRE_ONE: assert property (is_pre && !ap_bit && bank_open[bank] && bank_open[bank ^ 3'h1]
                                 |=> !BANK_OPEN[$past(bank)] && BANK_OPEN[$past(bank) ^ 3'h1])
      else $error("single bank precharge hit the wrong bank");
   AST_AP_ENGAGE: assert property ((is_rd || is_wr) && ap_bit |=> bank_ap[$past(bank)])
      else $error("auto precharge not engaged");
   AST_MASK_LANES: assert property (ARRAY_WE |-> ARRAY_BYTE_EN == ~$past(mask))
      else $error("byte enables do not follow the write mask");
   AST_READ_NO_LANES: assert property (!ARRAY_WE |-> ARRAY_BYTE_EN == 4'h0)
      else $error("byte lanes enabled outside a write");
   AST_WR_AFTER_DATA: assert property (ARRAY_WE |-> !$rose(BANK_PRECHARGING[ARRAY_WR_BANK]))
      else $error("precharge began while write data still stored");
   AST_ANY_BANK: assert property (wr_tap |=> ARRAY_WE && ARRAY_WR_BANK == $past(wr_entry[12:10]))
      else $error("interrupting write not steered to its bank");
   AST_BL4_TWO: assert property (wr_tap && !bl8 ##1 !wr_tap ##1 !wr_tap |-> ARRAY_WE ##1 !ARRAY_WE)
      else $error("four-beat write did not span two clocks");
   COV_WR_INTERRUPT: cover property (wr_tap && bl8 ##2 wr_tap);
   COV_PRE_ALL: cover property (is_pre && ap_bit);
   COV_READ_AP: cover property (is_rd && ap_bit);
endmodule

// file: core/ddrbp_pkg.sv
package ddrbp_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_MODE = 12'h000;
   localparam logic [11:0] OFF_LATENCY = 12'h004;
   localparam logic [11:0] OFF_TIMING = 12'h008;
   localparam logic [11:0] OFF_STATUS = 12'h00c;
   // mode register fields
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_ORDER_BIT = 3;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [3:0] MODE_RESET = 4'h2;
   // latency register fields
   localparam int LAT_AL_LSB = 0;
   localparam int LAT_CL_LSB = 4;
   localparam int LAT_WR_LSB = 8;
   localparam logic [10:0] LATENCY_RESET = 11'h330;
   localparam logic [2:0] CL_MIN = 3'h2;
   // timing register fields, all in clock cycles
   localparam int TIM_MIN_ACTIVE_TIME_LSB = 0;
   localparam int TIM_RTP_LSB = 8;
   localparam int TIM_TRP_LSB = 16;
   localparam logic [19:0] TIMING_RESET = 20'h32009;
   localparam logic [3:0] RTP_FLOOR = 4'h2;
   localparam logic [2:0] PREFETCH_STEP = 3'h2;
   // status register fields
   localparam int STAT_OPEN_LSB = 0;
   localparam int STAT_PRE_LSB = 8;
   localparam int STAT_WR_BIT = 16;
   localparam int STAT_RD_BIT = 17;
   // command codes on chip select, row, column and write strobes
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam int PRECHARGE_ALL_BIT_POS = 10;
   // pin bundle value while in reset: deselected, all else low
   localparam logic [55:0] PIN_IDLE = 56'hf0000000000000;
   // scheduled column entry layout
   localparam int ENT_VALID = 14;
   localparam int ENT_WRITE = 13;
   localparam int ENT_BANK_LSB = 10;
endpackage

// file: core/ddrbp_bank.sv
`timescale 1ns/1ps
module ddrbp_bank (
   // clock and control
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // decoded commands for this bank
   input wire logic activate,
   input wire logic precharge,
   input wire logic access,
   input wire logic access_write,
   input wire logic auto_pre,
   // delays in cycles, each at least one
   input wire logic [5:0] ap_delay,
   input wire logic [5:0] rtp_delay,
   input wire logic [4:0] min_active_time,
   input wire logic [3:0] row_precharge_time,
   // bank state
   output logic is_open,
   output logic is_precharging,
   output logic ap_pending
);
   logic [4:0] ras_cnt;
   logic [5:0] ap_cnt;
   logic [5:0] rtp_cnt;
   logic [3:0] trp_cnt;

   // internal precharge waits for due time, active lockout and read-to-precharge
   wire ras_met = (ras_cnt == 5'h00);
   wire rtp_met = (rtp_cnt == 6'h00);
   wire auto_start = ap_pending && (ap_cnt == 6'h00) && ras_met && rtp_met && is_open;
   wire pre_start = (precharge && is_open) || auto_start;

   // active lockout counter
   always_ff @(posedge clk) begin
      if (reset) begin
         ras_cnt <= 5'h00;
      end else if (ce) begin
         if (activate) begin
            ras_cnt <= min_active_time - 5'h01;
         end else if (!ras_met) begin
            ras_cnt <= ras_cnt - 5'h01;
         end
      end
   end

   // read-to-precharge counter, reloaded by every read to the bank
   always_ff @(posedge clk) begin
      if (reset) begin
         rtp_cnt <= 6'h00;
      end else if (ce) begin
         if (access && !access_write) begin
            rtp_cnt <= rtp_delay - 6'h01;
         end else if (!rtp_met) begin
            rtp_cnt <= rtp_cnt - 6'h01;
         end
      end
   end

   // auto-precharge due counter; a new access with auto-precharge reloads it from the programmed length
   always_ff @(posedge clk) begin
      if (reset) begin
         ap_cnt <= 6'h00;
         ap_pending <= 1'b0;
      end else if (ce) begin
         if (ap_cnt != 6'h00) begin
            ap_cnt <= ap_cnt - 6'h01;
         end
         if (pre_start) begin
            ap_pending <= 1'b0;
         end
         if (access && auto_pre) begin
            ap_pending <= 1'b1;
            ap_cnt <= ap_delay - 6'h01;
         end
      end
   end

   // open and precharge state; precharge period begins right at the start edge
   always_ff @(posedge clk) begin
      if (reset) begin
         is_open <= 1'b0;
         is_precharging <= 1'b0;
         trp_cnt <= 4'h0;
      end else if (ce) begin
         if (pre_start) begin
            is_open <= 1'b0;
            is_precharging <= 1'b1;
            trp_cnt <= row_precharge_time - 4'h1;
         end else if (is_precharging) begin
            if (trp_cnt == 4'h0) begin
               is_precharging <= 1'b0;
            end else begin
               trp_cnt <= trp_cnt - 4'h1;
            end
         end
         if (activate) begin
            is_open <= 1'b1;
         end
      end
   end

   // helper ages for the checks below
   logic [6:0] age_act;
   logic [6:0] age_ap;
   logic [5:0] ap_hold;
   always_ff @(posedge clk) begin
      if (reset) begin
         age_act <= 7'h7f;
         age_ap <= 7'h7f;
         ap_hold <= 6'h01;
      end else if (ce) begin
         age_act <= activate ? 7'h00 : ((age_act == 7'h7f) ? age_act : age_act + 7'h01);
         age_ap <= (access && auto_pre) ? 7'h00 : ((age_ap == 7'h7f) ? age_ap : age_ap + 7'h01);
         if (access && auto_pre) begin
            ap_hold <= ap_delay;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_RAS_LOCKOUT: assert property (ce && auto_start |-> age_act >= {2'h0, min_active_time} - 7'h01)
      else $error("auto precharge started inside minimum active time");
   AST_AP_NOT_EARLY: assert property (ce && auto_start |-> age_ap >= {1'h0, ap_hold} - 7'h01)
      else $error("auto precharge started before its due edge");
   AST_PRE_CLOSES: assert property (ce && precharge && is_open && !activate |=> !is_open && is_precharging)
      else $error("precharge did not close the bank");
   AST_TRP_HOLDS: assert property (ce && pre_start && row_precharge_time == 4'h2 && !activate ##1 ce |=> is_precharging)
      else $error("precharge period shorter than programmed");
   COV_AUTO_START: cover property (ce && auto_start);
endmodule

// file: tb/ddrbp_ctl_model.sv
`timescale 1ns/1ps
// far-side controller model: command strobes, bank and address, write data with byte mask
module ddrbp_ctl_model (
   // clock
   input wire logic clk,
   // command pins
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] bank,
   output logic [12:0] addr,
   // write data and byte mask
   output logic [31:0] dq_pair,
   output logic [3:0] byte_mask
);
   logic [7:0] beat = 8'h01;
   // data and mask step together every clock, so a stale beat never passes for a fresh one
   always @(posedge clk) begin
      beat <= beat + 8'h01;
   end
   assign dq_pair = {4{beat}};
   assign byte_mask = beat[3:0];
   // deselected at time zero
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      bank = 3'h0;
      addr = 13'h0;
   end
   // one command for one clock, then deselect with bank and address inverted; back-to-back calls
   // land two clocks apart, eight-beat bursts are cut only by the same kind, auto-precharge ones included
   task automatic cmd(input logic [3:0] code, input logic [2:0] b, input logic ap, input logic [9:0] col);
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= code;
      bank <= b;
      addr <= {2'h0, ap, col};
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hf;
      bank <= ~b;
      addr <= ~{2'h0, ap, col};
   endtask
   // idle clocks that let active, read-to-precharge, recovery and precharge limits expire
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
   endtask
endmodule

// file: tb/test_ddrbp_core.sv
`timescale 1ns/1ps
// register bus tasks and command sequences through the controller model
module test_ddrbp_core;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic cs_n, ras_n, cas_n, we_n, hreadyout, hresp, array_we, array_re;
   logic [2:0] bank;
   logic [12:0] addr;
   logic [3:0] byte_mask, byte_en;
   logic [7:0] bank_open, bank_pre;
   logic [31:0] dq_pair, array_wdata, hrdata, rd;
   logic ce = 1'b1;
   logic [2:0] wr_bank, rd_bank;
   logic [9:0] wr_col, rd_col;
   logic [12:0] wr_last = 13'h0;
   logic [12:0] rd_last = 13'h0;
   int err_count = 0;
   int checks = 0;
   // 50 MHz core clock
   always #10 clk = ~clk;
   // device and far-side controller
   ddrbp_core i_ddrbp_core (.CORE_CLK(clk), .RESET(reset), .CORE_CE(ce), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .BANK_SELECT_BIT0(bank[0]), .BANK_SELECT_BIT1(bank[1]),
      .BANK_SELECT_BIT2(bank[2]), .ADDR(addr), .DQ_PAIR(dq_pair), .WRITE_BYTE_MASK(byte_mask), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ARRAY_WE(array_we), .ARRAY_WR_BANK(wr_bank),
      .ARRAY_WR_COL(wr_col), .ARRAY_WDATA(array_wdata), .ARRAY_BYTE_EN(byte_en), .ARRAY_RE(array_re),
      .ARRAY_RD_BANK(rd_bank), .ARRAY_RD_COL(rd_col), .BANK_OPEN(bank_open), .BANK_PRECHARGING(bank_pre));
   ddrbp_ctl_model i_ddrbp_ctl_model (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .bank(bank), .addr(addr), .dq_pair(dq_pair), .byte_mask(byte_mask));
   // compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // wait, bounded, for the slave to take the current phase
   task automatic ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         err_count++;
         test_done();
      end
   endtask
   // single word transfer: address phase, then data phase; read data taken at its closing edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      ready();
      htrans <= 2'h0;
      hwdata <= wd;
      ready();
      rd = hrdata;
   endtask
   // selected bank or array signal
   function automatic logic probe(input int sel, input int b);
      case (sel)
         0: return bank_open[b];
         1: return bank_pre[b];
         2: return array_we;
         default: return array_re;
      endcase
   endfunction
   // clocks until the selected signal first reads high
   task automatic rise(input int sel, input int b, input int exp, input string name);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (probe(sel, b) !== 1'b1 && k < 40);
      check(name, k, exp);
      if (k >= 40) test_done();
   endtask
   // clocks the selected signal is high within a window
   task automatic high(input int sel, input int b, input int win, input int exp, input string name);
      int k;
      k = 0;
      repeat (win) begin
         @(posedge clk);
         #1;
         if (probe(sel, b) === 1'b1) k++;
      end
      check(name, k, exp);
   endtask
   // stored beats carry the mask that travelled with them; nothing is enabled otherwise
   always @(posedge clk) begin
      if (array_we === 1'b1) check("byte enable", {28'h0, byte_en}, {28'h0, ~array_wdata[3:0]});
      else if (reset === 1'b0) check("idle byte enable", {28'h0, byte_en}, 32'h0);
      // last beat pair of each burst, for the column order checks
      if (array_we === 1'b1) wr_last <= {wr_bank, wr_col};
      if (array_re === 1'b1) rd_last <= {rd_bank, rd_col};
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      ahb(1'b0, 32'h0, 32'h0);
      check("mode", rd, 32'h2);
      check("response", {31'h0, hresp}, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      check("latency", rd, 32'h330);
      ahb(1'b1, 32'h10, 32'hffff);
      ahb(1'b1, 32'hc, 32'hffff);
      ahb(1'b0, 32'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      // with the enable low the write must not land
      ce <= 1'b0;
      ahb(1'b1, 32'h0, 32'h3);
      ce <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0);
      check("frozen mode", rd, 32'h2);
      $display("registers done");
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h1, 1'b0, 10'h0);
      rise(0, 1, 2, "open bank");
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h0, 1'b0, 10'h0);
      i_ddrbp_ctl_model.gap(12);
      ahb(1'b0, 32'hc, 32'h0);
      check("status", rd, 32'h3);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_PRECHARGE, 3'h1, 1'b0, 10'h0);
      rise(1, 1, 2, "close one");
      check("open after one", {24'h0, bank_open}, 32'h1);
      i_ddrbp_ctl_model.gap(6);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_PRECHARGE, 3'h1, 1'b1, 10'h0);
      rise(1, 0, 2, "close all");
      check("open after all", {24'h0, bank_open}, 32'h0);
      check("precharging after all", {24'h0, bank_pre}, 32'h1);
      $display("bank select done");
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h2, 1'b0, 10'h0);
      i_ddrbp_ctl_model.gap(12);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h2, 1'b0, 10'h4);
      high(3, 0, 10, 2, "read beats");
      check("read last pair", {19'h0, rd_last}, {19'h0, 3'h2, 10'h006});
      check("open after read", {31'h0, bank_open[2]}, 32'h1);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_WRITE, 3'h2, 1'b0, 10'h1);
      high(2, 0, 8, 2, "four-beat write");
      check("write last pair", {19'h0, wr_last}, {19'h0, 3'h2, 10'h003});
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h2, 1'b1, 10'h0);
      rise(1, 2, 4, "read auto precharge");
      i_ddrbp_ctl_model.gap(6);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h0, 1'b0, 10'h0);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h0, 1'b1, 10'h0);
      rise(1, 0, 9, "active lockout");
      ahb(1'b1, 32'h8, 32'h20509);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h3, 1'b0, 10'h0);
      i_ddrbp_ctl_model.gap(12);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h3, 1'b1, 10'h0);
      rise(1, 3, 7, "read to precharge hold");
      high(1, 3, 6, 1, "precharge period");
      $display("auto precharge done");
      ahb(1'b1, 32'h0, 32'h3);
      ahb(1'b0, 32'h0, 32'h0);
      check("mode eight", rd, 32'h3);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h1, 1'b0, 10'h0);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h6, 1'b0, 10'h0);
      i_ddrbp_ctl_model.gap(12);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h1, 1'b0, 10'h0);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_READ, 3'h6, 1'b1, 10'h8);
      // the cut burst's first pair lies before the window, so one plus a full four
      high(3, 0, 14, 5, "interrupted reads");
      check("cut read last pair", {19'h0, rd_last}, {19'h0, 3'h6, 10'h00e});
      check("open after read cut", {24'h0, bank_open}, 32'h2);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_ACTIVATE, 3'h4, 1'b0, 10'h0);
      i_ddrbp_ctl_model.gap(12);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_WRITE, 3'h1, 1'b0, 10'h0);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_WRITE, 3'h1, 1'b0, 10'h4);
      high(2, 0, 16, 6, "interrupted writes");
      check("cut write last pair", {19'h0, wr_last}, {19'h0, 3'h1, 10'h002});
      i_ddrbp_ctl_model.gap(6);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_WRITE, 3'h1, 1'b0, 10'h0);
      i_ddrbp_ctl_model.cmd(ddrbp_pkg::CMD_WRITE, 3'h4, 1'b1, 10'h0);
      rise(1, 4, 11, "write auto precharge");
      check("open after write cut", {24'h0, bank_open}, 32'h2);
      check("ap write last pair", {19'h0, wr_last}, {19'h0, 3'h4, 10'h006});
      $display("interrupt done");
      test_done();
   end
endmodule
